/* File: thf_defs.svh */
// Offsets, field positions, reset values, write masks and timing counts
// for the thermal fan register bank. Included by the bank and its checker.
`ifndef THF_DEFS_SVH
`define THF_DEFS_SVH
`define THF_A_LTEMP 8'h00
`define THF_A_RTEMP_HI 8'h01
`define THF_A_ALERT 8'h02
`define THF_A_CFG 8'h03
`define THF_A_CONV 8'h04
`define THF_A_LHIGH 8'h05
`define THF_A_RHIGH_HI 8'h07
`define THF_A_RLOW_HI 8'h08
`define THF_A_CFG_M 8'h09
`define THF_A_CONV_M 8'h0A
`define THF_A_LHIGH_M 8'h0B
`define THF_A_RHIGH_HI_M 8'h0D
`define THF_A_RLOW_HI_M 8'h0E
`define THF_A_ONESHOT 8'h0F
`define THF_A_RTEMP_LO 8'h10
`define THF_A_ROFS_HI 8'h11
`define THF_A_ROFS_LO 8'h12
`define THF_A_RHIGH_LO 8'h13
`define THF_A_RLOW_LO 8'h14
`define THF_A_AMASK 8'h16
`define THF_A_CRIT 8'h19
`define THF_A_CRIT_HYS 8'h21
`define THF_A_TCNT_LO 8'h46
`define THF_A_TCNT_HI 8'h47
`define THF_A_TLIM_LO 8'h48
`define THF_A_TLIM_HI 8'h49
`define THF_A_FANCFG 8'h4A
`define THF_A_ENABLE_A 8'h4B
`define THF_A_DUTY 8'h4C
`define THF_A_FREQ 8'h4D
`define THF_A_LHYS 8'h4F
`define THF_A_LUT_HI 4'h5
`define THF_A_FILTER 8'hBF
`define THF_A_MAKER 8'hFE
`define THF_A_DIEREV 8'hFF
`define THF_R_CFG 8'h00
`define THF_R_CONV 8'h08
`define THF_R_TEMP70 8'h46
`define THF_R_ZERO 8'h00
`define THF_R_AMASK 8'hA4
`define THF_R_CRIT 8'h55
`define THF_R_CRIT_HYS 8'h0A
`define THF_R_TLIM 8'hFF
`define THF_R_FANCFG 8'h20
`define THF_R_ENABLE_A 8'h3F
`define THF_R_FREQ 8'h17
`define THF_R_LHYS 8'h04
`define THF_R_LUT_TEMP 8'h7F
`define THF_R_LUT_DUTY 8'h3F
`define THF_M_CFG 8'hE7
`define THF_M_CONV 8'h0F
`define THF_M_FRAC 8'hE0
`define THF_M_AMASK 8'h5B
`define THF_F_AMASK 8'hA4
`define THF_M_FANCFG 8'h3B
`define THF_M_SIX 8'h3F
`define THF_M_FIVE 8'h1F
`define THF_M_FILTER 8'h07
`define THF_B_PROGRAM 5
`define THF_B_POLARITY 4
`define THF_B_CLKSEL 3
`define THF_CLK_HZ 40000000
`define THF_FAST_HZ 360000
`define THF_SLOW_HZ 1400
`define THF_FAST_DIV (`THF_CLK_HZ / `THF_FAST_HZ)
`define THF_SLOW_DIV (`THF_CLK_HZ / `THF_SLOW_HZ)
`endif

/* File: thf_pkg.sv */
// Types shared by the thermal fan register bank.
// Assumes thf_defs.svh sits in the include path.
package thf_pkg;
   typedef logic [7:0] thf_byte_t;
   typedef logic [3:0] thf_level_t;
   typedef logic [14:0] thf_div_t;
   typedef enum logic [1:0] {thf_hold, thf_rise, thf_fall} thf_step_t;
endpackage

/* File: thf_regs.sv */
// Register bank of a remote-diode thermal sensor with fan drive control.
// Assumes a serial protocol engine issuing read/write strobes on clk and a
// conversion engine presenting fresh measurements with meas_update.
`timescale 1ns/1ps
`include "thf_defs.svh"

// Operation
// - Mirror addresses reach the same storage as their primary address.
// - Duty register is read-only unless program bit set, then host writable.
// - Remote offset upper and lower bytes are read-write, reset to zero.
// - Remote high limit upper resets to 0x46, lower to zero.
// - Remote low limit upper and lower bytes reset to zero.
// - Critical limit resets 0x55, its hysteresis 0x0A, both read-write.
// - Filter register holds filter select and comparator mode, upper bits zero.
// - Tach counts read-only; tach limits read-write, resetting to 0xFF.
// - Local temperature read-only; local high limit read-write, resets 0x46.
// - Reserved addresses hold no storage.
// - Fan config 0x20, spin-up 0x3F, frequency 0x17, hysteresis 0x04, duty zero.
// - Main configuration clears, conversion rate 0x08, alert mask 0xA4.
// - With program bit clear, duty follows temperature and table; both read-only.
// - Master drive clock is 360 kHz for select 0, 1.4 kHz for select 1.
module thf_regs
   import thf_pkg::*;
#(
   parameter int SLOW_DIV = `THF_SLOW_DIV,
   // Identification values are arbitrary
   parameter thf_byte_t MAKER_CODE = 8'h5A,
   parameter thf_byte_t DIE_REV_CODE = 8'h3C
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic meas_update,
   input wire logic [7:0] local_temp_in,
   input wire logic [7:0] remote_temp_high_in,
   input wire logic [7:0] remote_temp_low_in,
   input wire logic [7:0] alert_flags_in,
   input wire logic [7:0] tach_count_lower_in,
   input wire logic [7:0] tach_count_upper_in,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic single_conversion_start,
   output logic [7:0] device_configuration,
   output logic [7:0] conversion_rate,
   output logic [7:0] local_high_limit,
   output logic [7:0] remote_high_limit_upper,
   output logic [7:0] remote_high_limit_lower,
   output logic [7:0] remote_low_limit_upper,
   output logic [7:0] remote_low_limit_lower,
   output logic [7:0] remote_offset_upper,
   output logic [7:0] remote_offset_lower,
   output logic [7:0] alert_mask,
   output logic [7:0] remote_critical_limit,
   output logic [7:0] remote_critical_hysteresis,
   output logic [7:0] tach_limit_lower,
   output logic [7:0] tach_limit_upper,
   output logic [7:0] fan_drive_tach_config,
   output logic [7:0] fan_enable_a_config,
   output logic [7:0] fan_duty_value,
   output logic [7:0] fan_drive_frequency,
   output logic [7:0] lookup_hysteresis,
   output logic [7:0] remote_filter_config,
   output logic drive_master_tick
);

   // ---------------------------------------------------------------
   // Address folding
   // ---------------------------------------------------------------
   thf_byte_t addr_c;
   logic duty_program_enable;
   logic drive_clock_select;
   logic lut_hit;

   assign duty_program_enable = fan_drive_tach_config[`THF_B_PROGRAM];
   assign drive_clock_select = fan_drive_tach_config[`THF_B_CLKSEL];
   assign lut_hit = (reg_addr[7:4] == `THF_A_LUT_HI);

   always_comb
   begin
      if (reg_addr == `THF_A_CFG_M)
         addr_c = `THF_A_CFG;
      else if (reg_addr == `THF_A_CONV_M)
         addr_c = `THF_A_CONV;
      else if (reg_addr == `THF_A_LHIGH_M)
         addr_c = `THF_A_LHIGH;
      else if (reg_addr == `THF_A_RHIGH_HI_M)
         addr_c = `THF_A_RHIGH_HI;
      else if (reg_addr == `THF_A_RLOW_HI_M)
         addr_c = `THF_A_RLOW_HI;
      else
         addr_c = reg_addr;
   end

   // ---------------------------------------------------------------
   // Measurement capture
   // ---------------------------------------------------------------
   thf_byte_t local_temperature;
   thf_byte_t remote_temperature_high;
   thf_byte_t remote_temperature_low;
   thf_byte_t alert_flags;
   thf_byte_t tach_count_lower;
   thf_byte_t tach_count_upper;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         local_temperature <= `THF_R_ZERO;
         remote_temperature_high <= `THF_R_ZERO;
         remote_temperature_low <= `THF_R_ZERO;
         alert_flags <= `THF_R_ZERO;
         tach_count_lower <= `THF_R_ZERO;
         tach_count_upper <= `THF_R_ZERO;
      end
      else if (meas_update)
      begin
         local_temperature <= local_temp_in;
         remote_temperature_high <= remote_temp_high_in;
         remote_temperature_low <= remote_temp_low_in & `THF_M_FRAC;
         alert_flags <= alert_flags_in;
         tach_count_lower <= tach_count_lower_in;
         tach_count_upper <= tach_count_upper_in;
      end
   end

   // ---------------------------------------------------------------
   // Configuration and limit registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         device_configuration <= `THF_R_CFG;
         conversion_rate <= `THF_R_CONV;
         alert_mask <= `THF_R_AMASK;
         local_high_limit <= `THF_R_TEMP70;
         remote_high_limit_upper <= `THF_R_TEMP70;
         remote_high_limit_lower <= `THF_R_ZERO;
         remote_low_limit_upper <= `THF_R_ZERO;
         remote_low_limit_lower <= `THF_R_ZERO;
         remote_offset_upper <= `THF_R_ZERO;
         remote_offset_lower <= `THF_R_ZERO;
         remote_critical_limit <= `THF_R_CRIT;
         remote_critical_hysteresis <= `THF_R_CRIT_HYS;
         remote_filter_config <= `THF_R_ZERO;
      end
      else if (reg_wr)
      begin
         if (addr_c == `THF_A_CFG)
            device_configuration <= reg_wdata & `THF_M_CFG;
         else if (addr_c == `THF_A_CONV)
            conversion_rate <= reg_wdata & `THF_M_CONV;
         else if (addr_c == `THF_A_AMASK)
            alert_mask <= (reg_wdata & `THF_M_AMASK) | `THF_F_AMASK;
         else if (addr_c == `THF_A_LHIGH)
            local_high_limit <= reg_wdata;
         else if (addr_c == `THF_A_RHIGH_HI)
            remote_high_limit_upper <= reg_wdata;
         else if (addr_c == `THF_A_RHIGH_LO)
            remote_high_limit_lower <= reg_wdata & `THF_M_FRAC;
         else if (addr_c == `THF_A_RLOW_HI)
            remote_low_limit_upper <= reg_wdata;
         else if (addr_c == `THF_A_RLOW_LO)
            remote_low_limit_lower <= reg_wdata & `THF_M_FRAC;
         else if (addr_c == `THF_A_ROFS_HI)
            remote_offset_upper <= reg_wdata;
         else if (addr_c == `THF_A_ROFS_LO)
            remote_offset_lower <= reg_wdata & `THF_M_FRAC;
         else if (addr_c == `THF_A_CRIT)
            remote_critical_limit <= reg_wdata;
         else if (addr_c == `THF_A_CRIT_HYS)
            remote_critical_hysteresis <= reg_wdata;
         else if (addr_c == `THF_A_FILTER)
            remote_filter_config <= reg_wdata & `THF_M_FILTER;
      end
   end

   // ---------------------------------------------------------------
   // Fan control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fan_drive_tach_config <= `THF_R_FANCFG;
         fan_enable_a_config <= `THF_R_ENABLE_A;
         fan_drive_frequency <= `THF_R_FREQ;
         lookup_hysteresis <= `THF_R_LHYS;
         tach_limit_lower <= `THF_R_TLIM;
         tach_limit_upper <= `THF_R_TLIM;
      end
      else if (reg_wr)
      begin
         if (addr_c == `THF_A_FANCFG)
            fan_drive_tach_config <= reg_wdata & `THF_M_FANCFG;
         else if (addr_c == `THF_A_ENABLE_A)
            fan_enable_a_config <= reg_wdata & `THF_M_SIX;
         else if (addr_c == `THF_A_FREQ)
            fan_drive_frequency <= reg_wdata & `THF_M_FIVE;
         else if (addr_c == `THF_A_LHYS)
            lookup_hysteresis <= reg_wdata & `THF_M_FIVE;
         else if (addr_c == `THF_A_TLIM_LO)
            tach_limit_lower <= reg_wdata;
         else if (addr_c == `THF_A_TLIM_HI)
            tach_limit_upper <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Single conversion trigger
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         single_conversion_start <= 1'b0;
      else
         single_conversion_start <= reg_wr && (addr_c == `THF_A_ONESHOT);
   end

   // ---------------------------------------------------------------
   // Lookup table: even index threshold, odd index duty
   // ---------------------------------------------------------------
   thf_byte_t lut [16];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 16; i++)
            lut[i] <= (i % 2 == 0) ? `THF_R_LUT_TEMP : `THF_R_LUT_DUTY;
      end
      else if (reg_wr && lut_hit && duty_program_enable)
      begin
         if (reg_addr[0])
            lut[reg_addr[3:0]] <= reg_wdata & `THF_M_SIX;
         else
            lut[reg_addr[3:0]] <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Automatic duty from temperature with hysteresis
   // ---------------------------------------------------------------
   thf_level_t level;
   thf_level_t next_level;
   thf_level_t up_cnt;
   thf_level_t dn_cnt;
   thf_step_t step;
   logic [3:0] duty_idx;
   logic [8:0] rt_ext;
   logic [8:0] thr_low;

   always_comb
   begin
      up_cnt = 4'h0;
      dn_cnt = 4'h0;
      rt_ext = {remote_temperature_high[7], remote_temperature_high};
      thr_low = 9'h000;
      for (int i = 0; i < 8; i++)
      begin
         thr_low = {lut[2 * i][7], lut[2 * i]} - {4'h0, lookup_hysteresis[4:0]};
         if ($signed(remote_temperature_high) >= $signed(lut[2 * i]))
            up_cnt = up_cnt + 4'h1;
         if ($signed(rt_ext) >= $signed(thr_low))
            dn_cnt = dn_cnt + 4'h1;
      end
      if (up_cnt > level)
         step = thf_rise;
      else if (dn_cnt < level)
         step = thf_fall;
      else
         step = thf_hold;
      case (step)
         thf_rise: next_level = up_cnt;
         thf_fall: next_level = dn_cnt;
         default: next_level = level;
      endcase
      duty_idx = {3'(next_level - 4'h1), 1'b1};
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         level <= 4'h0;
         fan_duty_value <= `THF_R_ZERO;
      end
      else if (duty_program_enable)
      begin
         level <= 4'h0;
         if (reg_wr && addr_c == `THF_A_DUTY)
            fan_duty_value <= reg_wdata & `THF_M_SIX;
      end
      else
      begin
         level <= next_level;
         if (next_level == 4'h0)
            fan_duty_value <= `THF_R_ZERO;
         else
            fan_duty_value <= lut[duty_idx] & `THF_M_SIX;
      end
   end

   // ---------------------------------------------------------------
   // Master drive clock enable
   // ---------------------------------------------------------------
   thf_div_t div_cnt;
   thf_div_t div_last;

   assign div_last = drive_clock_select ? thf_div_t'(SLOW_DIV - 1) :
                     thf_div_t'(`THF_FAST_DIV - 1);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt <= '0;
         drive_master_tick <= 1'b0;
      end
      else if (div_cnt >= div_last)
      begin
         div_cnt <= '0;
         drive_master_tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 15'h0001;
         drive_master_tick <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   thf_byte_t next_rdata;

   always_comb
   begin
      if (addr_c == `THF_A_LTEMP)
         next_rdata = local_temperature;
      else if (addr_c == `THF_A_RTEMP_HI)
         next_rdata = remote_temperature_high;
      else if (addr_c == `THF_A_RTEMP_LO)
         next_rdata = remote_temperature_low;
      else if (addr_c == `THF_A_ALERT)
         next_rdata = alert_flags;
      else if (addr_c == `THF_A_CFG)
         next_rdata = device_configuration;
      else if (addr_c == `THF_A_CONV)
         next_rdata = conversion_rate;
      else if (addr_c == `THF_A_LHIGH)
         next_rdata = local_high_limit;
      else if (addr_c == `THF_A_RHIGH_HI)
         next_rdata = remote_high_limit_upper;
      else if (addr_c == `THF_A_RHIGH_LO)
         next_rdata = remote_high_limit_lower;
      else if (addr_c == `THF_A_RLOW_HI)
         next_rdata = remote_low_limit_upper;
      else if (addr_c == `THF_A_RLOW_LO)
         next_rdata = remote_low_limit_lower;
      else if (addr_c == `THF_A_ROFS_HI)
         next_rdata = remote_offset_upper;
      else if (addr_c == `THF_A_ROFS_LO)
         next_rdata = remote_offset_lower;
      else if (addr_c == `THF_A_AMASK)
         next_rdata = alert_mask;
      else if (addr_c == `THF_A_CRIT)
         next_rdata = remote_critical_limit;
      else if (addr_c == `THF_A_CRIT_HYS)
         next_rdata = remote_critical_hysteresis;
      else if (addr_c == `THF_A_TCNT_LO)
         next_rdata = tach_count_lower;
      else if (addr_c == `THF_A_TCNT_HI)
         next_rdata = tach_count_upper;
      else if (addr_c == `THF_A_TLIM_LO)
         next_rdata = tach_limit_lower;
      else if (addr_c == `THF_A_TLIM_HI)
         next_rdata = tach_limit_upper;
      else if (addr_c == `THF_A_FANCFG)
         next_rdata = fan_drive_tach_config;
      else if (addr_c == `THF_A_ENABLE_A)
         next_rdata = fan_enable_a_config;
      else if (addr_c == `THF_A_DUTY)
         next_rdata = fan_duty_value;
      else if (addr_c == `THF_A_FREQ)
         next_rdata = fan_drive_frequency;
      else if (addr_c == `THF_A_LHYS)
         next_rdata = lookup_hysteresis;
      else if (lut_hit)
         next_rdata = lut[reg_addr[3:0]];
      else if (addr_c == `THF_A_FILTER)
         next_rdata = remote_filter_config;
      else if (addr_c == `THF_A_MAKER)
         next_rdata = MAKER_CODE;
      else if (addr_c == `THF_A_DIEREV)
         next_rdata = DIE_REV_CODE;
      else
         next_rdata = `THF_R_ZERO;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata <= `THF_R_ZERO;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end

endmodule

/* File: thf_host.sv */
// Host side of the register port: issues single-cycle read and write strobes.
// Assumes the bank answers a read within four cycles after the strobe edge.
`timescale 1ns/1ps
module thf_host
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ----------------------------------------
   // Bus cycles
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Released lines show the inverse
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
         @(posedge clk);
      d = (n < 4) ? reg_rdata : 8'hXX;
   endtask
endmodule

/* File: thf_regs_checker.sv */
// Port-level checks for the thermal fan register bank.
// Assumes a single clock domain; attached by the bind below.
`timescale 1ns/1ps
`include "thf_defs.svh"
module thf_regs_checker
#(
   parameter int SLOW_DIV = `THF_SLOW_DIV
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic single_conversion_start,
   input wire logic [7:0] device_configuration,
   input wire logic [7:0] conversion_rate,
   input wire logic [7:0] fan_drive_tach_config,
   input wire logic [7:0] fan_duty_value,
   input wire logic [7:0] remote_filter_config,
   input wire logic drive_master_tick
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Tick interval tracking
   // ----------------------------------------
   int gap;
   int div;
   logic clean;
   logic sel_q;
   assign div = fan_drive_tach_config[3] ? SLOW_DIV : `THF_FAST_DIV;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         gap <= 0;
         clean <= 1'b0;
         sel_q <= 1'b0;
      end
      else
      begin
         sel_q <= fan_drive_tach_config[3];
         gap <= drive_master_tick ? 1 : gap + 1;
         clean <= (drive_master_tick || clean) && (fan_drive_tach_config[3] == sel_q);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_read_answer: assert property (1'b1 |=> reg_rvalid == $past(reg_rd)) else $error("read answer late");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   a_mirror_cfg: assert property (reg_rd && (reg_addr == 8'h03 || reg_addr == 8'h09) |=>
      reg_rdata == $past(device_configuration)) else $error("configuration read wrong");
   a_conv_write: assert property (reg_wr && (reg_addr == 8'h04 || reg_addr == 8'h0A) |=>
      conversion_rate == ($past(reg_wdata) & 8'h0F)) else $error("conversion rate write wrong");
   a_duty_program: assert property (reg_wr && reg_addr == 8'h4C && fan_drive_tach_config[5] |=>
      fan_duty_value == ($past(reg_wdata) & 8'h3F)) else $error("duty write lost");
   a_unused_zero: assert property (remote_filter_config[7:3] == 5'h00 && fan_duty_value[7:6] == 2'h0
      && device_configuration[4:3] == 2'h0) else $error("unused bits set");
   a_reserved_read: assert property (reg_rd && (reg_addr == 8'h4E || reg_addr inside {[8'h60:8'hBE],
      [8'hC0:8'hFD]}) |=> reg_rdata == 8'h00) else $error("reserved read not zero");
   a_oneshot_pulse: assert property (reg_wr && reg_addr == 8'h0F |=> single_conversion_start)
      else $error("one-shot start missing");
   a_tick_period: assert property (drive_master_tick && clean && fan_drive_tach_config[3] == sel_q
      |-> gap == div) else $error("tick period wrong");
   a_tick_bound: assert property (clean && fan_drive_tach_config[3] == sel_q |-> gap <= div)
      else $error("tick overdue");

   cover property (drive_master_tick && clean && fan_drive_tach_config[3]);
   cover property (reg_wr && reg_addr == 8'h4C && fan_drive_tach_config[5]);
   cover property (reg_rd && reg_addr == 8'h09);
endmodule

bind thf_regs thf_regs_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .single_conversion_start(single_conversion_start), .device_configuration(device_configuration),
   .conversion_rate(conversion_rate), .fan_drive_tach_config(fan_drive_tach_config),
   .fan_duty_value(fan_duty_value), .remote_filter_config(remote_filter_config),
   .drive_master_tick(drive_master_tick));

/* File: thf_regs_test.sv */
// Self-checking bench for the thermal fan register bank.
// Assumes thf_host drives the register port and the checker is bound in.
`timescale 1ns/1ps
module thf_regs_test;
   localparam int SLOW = 20;
   // Identification values are arbitrary
   localparam logic [7:0] ID_M = 8'hC3;
   localparam logic [7:0] ID_D = 8'h9E;
   localparam logic [15:0] RST [25] = '{16'h0300, 16'h0408, 16'h0546, 16'h0746, 16'h0800, 16'h0900,
      16'h0A08, 16'h0B46, 16'h0D46, 16'h0E00, 16'h1100, 16'h1200, 16'h1300, 16'h1400, 16'h16A4,
      16'h1955, 16'h210A, 16'h48FF, 16'h49FF, 16'h4A20, 16'h4B3F, 16'h4C00, 16'h4D17, 16'h4F04, 16'hBF00};
   localparam logic [15:0] ONES [19] = '{16'h03E7, 16'h040F, 16'h05FF, 16'h07FF, 16'h08FF, 16'h11FF,
      16'h12E0, 16'h13E0, 16'h14E0, 16'h16FF, 16'h19FF, 16'h21FF, 16'h48FF, 16'h49FF, 16'h4A3B,
      16'h4B3F, 16'h4D1F, 16'h4F1F, 16'hBF07};
   localparam logic [15:0] RO [6] = '{16'h002B, 16'h0130, 16'h0255, 16'h10E0, 16'h469A, 16'h4747};
   localparam logic [23:0] MIR [5] = '{24'h090381, 24'h0A0405, 24'h0B0512, 24'h0D075C, 24'h0E0833};
   localparam logic [7:0] RSV [15] = '{8'h06, 8'h0C, 8'h15, 8'h17, 8'h18, 8'h1A, 8'h20, 8'h2F, 8'h40,
      8'h45, 8'h4E, 8'h60, 8'hBE, 8'hC0, 8'hFD};
   localparam logic [7:0] POR [15] = '{8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA4, 8'h55, 8'h0A,
      8'hFF, 8'hFF, 8'h3F, 8'h17, 8'h04};

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic meas_update = 1'b0;
   logic [7:0] rth = 8'h00;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [7:0] po [15];
   logic reg_wr, reg_rd, reg_rvalid;
   int err_total = 0;
   int n_tests = 0;

   always #12.5 clk = ~clk;

   thf_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

   thf_regs #(.SLOW_DIV(SLOW), .MAKER_CODE(ID_M), .DIE_REV_CODE(ID_D)) dut (.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .meas_update(meas_update), .local_temp_in(8'h2B), .remote_temp_high_in(rth),
      .remote_temp_low_in(8'hE0), .alert_flags_in(8'h55), .tach_count_lower_in(8'h9A),
      .tach_count_upper_in(8'h47), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .single_conversion_start(), .device_configuration(), .conversion_rate(), .local_high_limit(po[0]),
      .remote_high_limit_upper(po[1]), .remote_high_limit_lower(po[2]), .remote_low_limit_upper(po[3]),
      .remote_low_limit_lower(po[4]), .remote_offset_upper(po[5]), .remote_offset_lower(po[6]),
      .alert_mask(po[7]), .remote_critical_limit(po[8]), .remote_critical_hysteresis(po[9]),
      .tach_limit_lower(po[10]), .tach_limit_upper(po[11]), .fan_drive_tach_config(),
      .fan_enable_a_config(po[12]), .fan_duty_value(), .fan_drive_frequency(po[13]),
      .lookup_hysteresis(po[14]), .remote_filter_config(), .drive_master_tick());

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, got);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t addr %h got %h exp %h", $time, a, got, exp);
      end
   endtask

   task automatic chk_port(input int idx, input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH t=%0t port %0d got %h exp %h", $time, idx, g, e);
      end
   endtask

   task automatic meas(input logic [7:0] t);
      @(posedge clk);
      rth <= t;
      meas_update <= 1'b1;
      @(posedge clk);
      meas_update <= 1'b0;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      foreach (RST[i]) chk(RST[i][15:8], RST[i][7:0]);
      u_host.wr(8'h4A, 8'h20);
      u_host.wr(8'h4C, 8'hFF);
      chk(8'h4C, 8'h3F);
      u_host.wr(8'h50, 8'h20);
      u_host.wr(8'h51, 8'hEA);
      chk(8'h50, 8'h20);
      chk(8'h51, 8'h2A);
      meas(8'h30);
      foreach (RO[i]) u_host.wr(RO[i][15:8], 8'hFF);
      foreach (RO[i]) chk(RO[i][15:8], RO[i][7:0]);
      u_host.wr(8'h4A, 8'h00);
      u_host.wr(8'h4C, 8'h11);
      u_host.wr(8'h50, 8'h05);
      chk(8'h4C, 8'h2A);
      chk(8'h50, 8'h20);
      // Inside the hysteresis band the duty holds
      meas(8'h1E);
      chk(8'h4C, 8'h2A);
      meas(8'h10);
      chk(8'h4C, 8'h00);
      foreach (ONES[i]) u_host.wr(ONES[i][15:8], 8'hFF);
      foreach (ONES[i]) chk(ONES[i][15:8], ONES[i][7:0]);
      repeat (SLOW * 4) @(posedge clk);
      foreach (ONES[i]) u_host.wr(ONES[i][15:8], 8'h00);
      foreach (ONES[i]) chk(ONES[i][15:8], (ONES[i][15:8] == 8'h16) ? 8'hA4 : 8'h00);
      foreach (MIR[i])
      begin
         u_host.wr(MIR[i][23:16], MIR[i][7:0]);
         chk(MIR[i][15:8], MIR[i][7:0]);
         chk(MIR[i][23:16], MIR[i][7:0]);
      end
      foreach (RSV[i])
      begin
         u_host.wr(RSV[i], 8'hFF);
         chk(RSV[i], 8'h00);
      end
      chk(8'hFE, ID_M);
      chk(8'hFF, ID_D);
      u_host.wr(8'h0F, 8'h01);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      foreach (POR[i]) chk_port(i, po[i], POR[i]);
      chk(8'h04, 8'h08);
      chk(8'h4D, 8'h17);
      finish_test();
   end

   // Sequence needs about 560 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test();
   end
endmodule
